/* core/gptm_pkg.sv */
// Package: register map, fields, defaults and timing of the timer and mask block
package gptm_pkg;

    // ------------------------------------------------------------
    // Register indices and byte addresses (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [7:0] TTC_IDX      = 8'h11;
    localparam logic [7:0] GPT_HI_IDX   = 8'h12;
    localparam logic [7:0] GPT_LO_IDX   = 8'h13;
    localparam logic [7:0] MMASK_IDX    = 8'h14;
    localparam logic [7:0] TMASK_IDX    = 8'h15;
    localparam logic [7:0] MSTAT_IDX    = 8'h17;
    localparam logic [7:0] TSTAT_IDX    = 8'h18;
    localparam int         ADDR_W       = 8;
    localparam logic [7:0] TTC_ADDR     = 8'(TTC_IDX * 4);
    localparam logic [7:0] GPT_HI_ADDR  = 8'(GPT_HI_IDX * 4);
    localparam logic [7:0] GPT_LO_ADDR  = 8'(GPT_LO_IDX * 4);
    localparam logic [7:0] MMASK_ADDR   = 8'(MMASK_IDX * 4);
    localparam logic [7:0] TMASK_ADDR   = 8'(TMASK_IDX * 4);
    localparam logic [7:0] MSTAT_ADDR   = 8'(MSTAT_IDX * 4);
    localparam logic [7:0] TSTAT_ADDR   = 8'(TSTAT_IDX * 4);

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TRIG_MSB     = 7;
    localparam int TRIG_LSB     = 5;
    localparam int NRT_CMPL_BIT = 1;
    localparam int NRT_STEP_BIT = 0;
    localparam int M_OSC        = 7;
    localparam int M_FIFO       = 6;
    localparam int M_RXS        = 5;
    localparam int M_RXE        = 4;
    localparam int M_TXE        = 3;
    localparam int M_COL        = 2;
    localparam int M_TIM        = 1;
    localparam int M_ERR        = 0;
    localparam int T_DCT        = 7;
    localparam int T_NRE        = 6;
    localparam int T_GPE        = 5;
    localparam int T_EON        = 4;
    localparam int T_EOF        = 3;
    localparam int T_CAC        = 2;
    localparam int T_CAT        = 1;
    localparam int T_NFCT       = 0;

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0]  BYTE_RST     = 8'h00;
    localparam logic [15:0] GPT_RST      = 16'h0000;
    localparam logic [7:0]  MAIN_RDCLR   = 8'hFC;
    localparam logic [7:0]  MAIN_TIMCLR  = 8'h02;
    localparam logic [7:0]  MMASK_USED   = 8'hFC;

    // ------------------------------------------------------------
    // Timing: carrier periods per step
    // ------------------------------------------------------------
    localparam int         GP_STEP_FC    = 8;
    localparam int         NRT_SHORT_FC  = 64;
    localparam int         NRT_LONG_FC   = 4096;
    localparam logic [2:0] GP_PRE_LAST   = 3'(GP_STEP_FC - 1);

    // ------------------------------------------------------------
    // Trigger codes and timer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TRIG_CMD_ONLY  = 3'b000,
        TRIG_RX_END    = 3'b001,
        TRIG_RX_START  = 3'b010,
        TRIG_TX_END    = 3'b011
    } gptm_trig_e;

    typedef enum logic [0:0] {
        GPT_IDLE = 1'b0,
        GPT_RUN  = 1'b1
    } gptm_state_e;

endpackage

/* core/gptm_step_timer.sv */
// General purpose timer: 16-bit count of 8-carrier-period steps
`timescale 1ns/1ps
module gptm_step_timer
    import gptm_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    // Control
    input  wire logic        clear_i,
    input  wire logic        start_i,
    input  wire logic        fc_tick_i,
    input  wire logic [15:0] reload_i,
    // Status
    output logic             running_o,
    output logic             expired_o
);
    gptm_state_e state_q;
    logic [2:0]  pre_q;
    logic [15:0] count_q;

    assign running_o = (state_q == GPT_RUN);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || clear_i) begin
            state_q   <= GPT_IDLE;
            pre_q     <= 3'h0;
            count_q   <= GPT_RST;
            expired_o <= 1'b0;
        end else begin
            expired_o <= 1'b0;
            // A start while running restarts from the reload value
            if (start_i && reload_i != GPT_RST) begin
                state_q <= GPT_RUN;
                pre_q   <= 3'h0;
                count_q <= reload_i;
            end else begin
                case (state_q)
                    GPT_RUN: begin
                        if (fc_tick_i) begin
                            if (pre_q == GP_PRE_LAST) begin
                                pre_q <= 3'h0;
                                if (count_q == 16'h0001) begin
                                    state_q   <= GPT_IDLE;
                                    expired_o <= 1'b1;
                                end else begin
                                    count_q <= count_q - 16'h0001;
                                end
                            end else begin
                                pre_q <= pre_q + 3'h1;
                            end
                        end
                    end
                    default: begin
                        state_q <= GPT_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

/* core/gptm_sync.sv */
// Two-stage synchroniser for a level entering the system clock domain
`timescale 1ns/1ps
module gptm_sync (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    // Level in and out
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta_q;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

/* core/gptm_top.sv */
// Timer trigger control, general purpose timer and interrupt masking with APB access
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
// Function
// - Trigger code 000: timer starts only on the start-timer command.
// - Code 001 starts at end of reception; 010 at start of reception.
// - Code 011 starts at NFC end of transmission; expiry of a run it started switches field off.
// - Control bit 0 picks no-response step: 64 or 4096 carrier periods.
// - Control bit 1 selects the compliance mode of the no-response timer.
// - Timeout is 16 bits, high and low byte registers, 8 periods per step.
// - Timeout spans one step up to the full 16-bit value.
// - Main mask bits 7 to 2 suppress their matching interrupt sources.
// - Timer mask bits 7, 6, 5 suppress command, no-response, timer expiry.
// - Timer mask bits 4, 3 suppress external field on and off events.
// - Timer mask bit 2 suppresses collision-avoidance collision event.
// - Timer mask bit 1 suppresses guard-time-expired event.
// - Timer mask bit 0 suppresses bit-rate-recognized event.
// - Control and mask bits clear at reset and on set-default command.
// - Timer expiry sets its own timer status flag unless masked.
// - Reading main status clears bits 7 to 2; timer summary bit 1 clears on timer status read.
module gptm_top
    import gptm_pkg::*;
(
    // Clock and reset
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_n_i,
    // APB slave
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [gptm_pkg::ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]                pwdata_i,
    output logic      [31:0]                prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    // Carrier clock pin
    input  wire logic                       carrier_clk_i,
    // Commands and timer triggers
    input  wire logic                       cmd_start_gpt_i,
    input  wire logic                       cmd_set_default_i,
    input  wire logic                       rx_start_i,
    input  wire logic                       rx_end_i,
    input  wire logic                       tx_end_i,
    input  wire logic                       nfc_mode_i,
    // Interrupt sources
    input  wire logic                       osc_stable_i,
    input  wire logic                       fifo_level_i,
    input  wire logic                       bit_col_i,
    input  wire logic                       cmd_done_i,
    input  wire logic                       nrt_expire_i,
    input  wire logic                       field_on_i,
    input  wire logic                       field_off_i,
    input  wire logic                       ca_collision_i,
    input  wire logic                       guard_time_i,
    input  wire logic                       nfc_rate_i,
    // Outputs
    output logic                            irq_o,
    output logic                            rf_field_off_o,
    output logic                            gpt_running_o,
    output logic                            nrt_step_long_o,
    output logic                            nrt_compliance_o
);
    import gptm_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0]  trig_q;
    logic [7:0]  gp_timeout_msb_q;
    logic [7:0]  gp_timeout_lsb_q;
    logic [7:0]  main_mask_q;
    logic [7:0]  tim_mask_q;
    logic [7:0]  main_stat_q;
    logic [7:0]  main_stat_d;
    logic [7:0]  tim_stat_q;
    logic [7:0]  tim_stat_d;
    logic [7:0]  main_set;
    logic [7:0]  tim_set;
    logic [7:0]  main_clr;
    logic [7:0]  tim_clr;
    logic [31:0] rdata;
    logic        hit;
    logic        xfer;
    logic        wr;
    logic        rd;
    logic        dflt;
    logic        auto_trig;
    logic        gpt_start;
    logic        gpt_expire;
    logic        gpt_run;
    logic        nfc_armed_q;
    logic        fc_sync;
    logic        fc_prev_q;
    logic        fc_tick;

    assign dflt = cmd_set_default_i;

    // ------------------------------------------------------------
    // Carrier edge detection
    // ------------------------------------------------------------
    gptm_sync u_fc_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (carrier_clk_i),
        .sync_o    (fc_sync)
    );

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            fc_prev_q <= 1'b0;
        end else begin
            fc_prev_q <= fc_sync;
        end
    end

    assign fc_tick = fc_sync & ~fc_prev_q;

    // ------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------
    assign xfer = psel_i & penable_i & pready_o;
    assign wr   = xfer & pwrite_i;
    assign rd   = xfer & ~pwrite_i;

    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr_i)
            TTC_ADDR:    rdata[7:0] = {trig_q, 3'b000, nrt_compliance_o, nrt_step_long_o};
            GPT_HI_ADDR: rdata[7:0] = gp_timeout_msb_q;
            GPT_LO_ADDR: rdata[7:0] = gp_timeout_lsb_q;
            MMASK_ADDR:  rdata[7:0] = main_mask_q;
            TMASK_ADDR:  rdata[7:0] = tim_mask_q;
            MSTAT_ADDR:  rdata[7:0] = main_stat_q;
            TSTAT_ADDR:  rdata[7:0] = tim_stat_q;
            default:     hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~hit;
            prdata_o  <= (psel_i & penable_i & ~pready_o & ~pwrite_i) ? rdata : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || dflt) begin
            trig_q           <= BYTE_RST[2:0];
            nrt_compliance_o <= 1'b0;
            nrt_step_long_o  <= 1'b0;
            main_mask_q      <= BYTE_RST;
            tim_mask_q       <= BYTE_RST;
            gp_timeout_msb_q <= BYTE_RST;
            gp_timeout_lsb_q <= BYTE_RST;
        end else if (wr) begin
            case (paddr_i)
                TTC_ADDR: begin
                    trig_q           <= pwdata_i[TRIG_MSB:TRIG_LSB];
                    nrt_compliance_o <= pwdata_i[NRT_CMPL_BIT];
                    nrt_step_long_o  <= pwdata_i[NRT_STEP_BIT];
                end
                GPT_HI_ADDR: gp_timeout_msb_q <= pwdata_i[7:0];
                GPT_LO_ADDR: gp_timeout_lsb_q <= pwdata_i[7:0];
                MMASK_ADDR:  main_mask_q <= pwdata_i[7:0] & MMASK_USED;
                TMASK_ADDR:  tim_mask_q  <= pwdata_i[7:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Trigger selection and general purpose timer
    // ------------------------------------------------------------
    always_comb begin
        case (trig_q)
            TRIG_RX_END:   auto_trig = rx_end_i;
            TRIG_RX_START: auto_trig = rx_start_i;
            TRIG_TX_END:   auto_trig = tx_end_i & nfc_mode_i;
            default:       auto_trig = 1'b0;
        endcase
    end

    assign gpt_start = cmd_start_gpt_i | auto_trig;

    // Full 16-bit reload reaches 65535 steps; zero never starts
    gptm_step_timer u_gpt (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .clear_i   (dflt),
        .start_i   (gpt_start),
        .fc_tick_i (fc_tick),
        .reload_i  ({gp_timeout_msb_q, gp_timeout_lsb_q}),
        .running_o (gpt_run),
        .expired_o (gpt_expire)
    );

    // Field-off applies only to runs started by the NFC end of transmission
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || dflt) begin
            nfc_armed_q    <= 1'b0;
            rf_field_off_o <= 1'b0;
            gpt_running_o  <= 1'b0;
        end else begin
            gpt_running_o  <= gpt_run;
            rf_field_off_o <= gpt_expire & nfc_armed_q;
            if (gpt_start) begin
                nfc_armed_q <= auto_trig & (trig_q == TRIG_TX_END);
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, set wins over clear
    // ------------------------------------------------------------
    always_comb begin
        tim_set          = 8'h00;
        tim_set[T_DCT]   = cmd_done_i & ~tim_mask_q[T_DCT];
        tim_set[T_NRE]   = nrt_expire_i & ~tim_mask_q[T_NRE];
        tim_set[T_GPE]   = gpt_expire & ~tim_mask_q[T_GPE];
        tim_set[T_EON]   = field_on_i & ~tim_mask_q[T_EON];
        tim_set[T_EOF]   = field_off_i & ~tim_mask_q[T_EOF];
        tim_set[T_CAC]   = ca_collision_i & ~tim_mask_q[T_CAC];
        tim_set[T_CAT]   = guard_time_i & ~tim_mask_q[T_CAT];
        tim_set[T_NFCT]  = nfc_rate_i & ~tim_mask_q[T_NFCT];
        main_set         = 8'h00;
        main_set[M_OSC]  = osc_stable_i & ~main_mask_q[M_OSC];
        main_set[M_FIFO] = fifo_level_i & ~main_mask_q[M_FIFO];
        main_set[M_RXS]  = rx_start_i & ~main_mask_q[M_RXS];
        main_set[M_RXE]  = rx_end_i & ~main_mask_q[M_RXE];
        main_set[M_TXE]  = tx_end_i & ~main_mask_q[M_TXE];
        main_set[M_COL]  = bit_col_i & ~main_mask_q[M_COL];
        main_set[M_TIM]  = |tim_set;
        main_clr         = 8'h00;
        tim_clr          = 8'h00;
        if (rd && paddr_i == MSTAT_ADDR) begin
            main_clr = MAIN_RDCLR;
        end
        if (rd && paddr_i == TSTAT_ADDR) begin
            main_clr = main_clr | MAIN_TIMCLR;
            tim_clr  = 8'hFF;
        end
        if (wr && paddr_i == MSTAT_ADDR) begin
            main_clr = main_clr | pwdata_i[7:0];
        end
        if (wr && paddr_i == TSTAT_ADDR) begin
            tim_clr = tim_clr | pwdata_i[7:0];
        end
        main_stat_d = (main_stat_q & ~main_clr) | main_set;
        tim_stat_d  = (tim_stat_q & ~tim_clr) | tim_set;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || dflt) begin
            main_stat_q <= BYTE_RST;
            tim_stat_q  <= BYTE_RST;
            irq_o       <= 1'b0;
        end else begin
            main_stat_q <= main_stat_d;
            tim_stat_q  <= tim_stat_d;
            irq_o       <= |main_stat_q;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_trig_cmd_only: assert property (
        (trig_q == TRIG_CMD_ONLY && !cmd_start_gpt_i && !gpt_run && !dflt)
            |=> !gpt_run) else $error("timer started without command");

    a_trig_unused: assert property (
        (trig_q[2] && !cmd_start_gpt_i && !gpt_run && !dflt) |=> !gpt_run)
        else $error("unused trigger code started timer");

    a_trig_rx_end: assert property (
        (trig_q == TRIG_RX_END && rx_end_i && !dflt
            && {gp_timeout_msb_q, gp_timeout_lsb_q} != GPT_RST)
            |=> gpt_run ##1 gpt_running_o) else $error("end of rx did not start timer");

    a_field_switch: assert property (
        (gpt_expire && nfc_armed_q && !dflt) |=> rf_field_off_o)
        else $error("field not switched off on expiry");

    a_step_select: assert property (
        (wr && paddr_i == TTC_ADDR && !dflt) |=> nrt_step_long_o == $past(pwdata_i[NRT_STEP_BIT]))
        else $error("step bit not written");

    a_cmpl_mode: assert property (
        (wr && paddr_i == TTC_ADDR && !dflt) |=> nrt_compliance_o == $past(pwdata_i[NRT_CMPL_BIT]))
        else $error("compliance bit not written");

    a_set_default: assert property (
        dflt |=> (trig_q == 3'h0 && main_mask_q == 8'h00 && tim_mask_q == 8'h00
            && !nrt_step_long_o && !nrt_compliance_o)) else $error("defaults not loaded");

    a_gpe_flag: assert property (
        (gpt_expire && !tim_mask_q[T_GPE] && !dflt) |=> tim_stat_q[T_GPE] && main_stat_q[M_TIM])
        else $error("timer expiry flag missing");

    a_osc_masked: assert property (
        (main_mask_q[M_OSC] && !main_stat_q[M_OSC]) |=> !main_stat_q[M_OSC])
        else $error("masked source set main flag");

    a_dct_masked: assert property (
        (tim_mask_q[T_DCT] && !tim_stat_q[T_DCT]) |=> !tim_stat_q[T_DCT])
        else $error("masked source set timer flag");

    a_main_rdclr: assert property (
        (rd && paddr_i == MSTAT_ADDR && main_set[7:2] == 6'h00 && !dflt)
            |=> main_stat_q[7:2] == 6'h00
                && main_stat_q[1:0] == ($past(main_stat_q[1:0]) | $past(main_set[1:0])))
        else $error("main status not cleared by read");

    a_irq_level: assert property (
        (main_stat_q != 8'h00 && !dflt) |=> irq_o) else $error("interrupt not raised");

endmodule

/* verification/gp_timer_irq_mask_config_tb.sv */
// Self-checking bench for the timer trigger, timeout and interrupt mask block
`timescale 1ns/1ps
module gp_timer_irq_mask_config_tb;
    import gptm_pkg::*;
    typedef struct {
        logic [7:0] wa;
        logic [7:0] wd;
        int         ev;
        logic [7:0] ra;
        logic [7:0] ex;
    } gptm_row_s;
    localparam int RXS = 10, RXE = 11, TXE = 12, CMD = 13, DEF = 14, NONE = 15;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic        pready, pslverr, irq, rf_off, running, step_long, cmpl, fc, er;
    logic        fc_en = 1'b1, fo_seen = 1'b0, nfc = 1'b1;
    logic [14:0] ev = 15'h0000;
    int          bad_count = 0, n_checks = 0, cyc = 0;
    gptm_row_s   rows[$];
    logic [7:0]  ma[6] = '{8'h80, 8'h40, 8'h04, 8'h20, 8'h10, 8'h08};
    int          me[6] = '{0, 1, 2, RXS, RXE, TXE};
    logic [7:0]  tm[7] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
    initial forever #2 clk = ~clk;
    gptm_fc_src gptm_fc_src_i (.en_i(fc_en), .fc_o(fc));
    gptm_top gptm_top_i (
        .sys_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .carrier_clk_i(fc),
        .cmd_start_gpt_i(ev[CMD]), .cmd_set_default_i(ev[DEF]), .rx_start_i(ev[RXS]),
        .rx_end_i(ev[RXE]), .tx_end_i(ev[TXE]), .nfc_mode_i(nfc),
        .osc_stable_i(ev[0]), .fifo_level_i(ev[1]), .bit_col_i(ev[2]),
        .cmd_done_i(ev[3]), .nrt_expire_i(ev[4]), .field_on_i(ev[5]),
        .field_off_i(ev[6]), .ca_collision_i(ev[7]), .guard_time_i(ev[8]),
        .nfc_rate_i(ev[9]), .irq_o(irq), .rf_field_off_o(rf_off),
        .gpt_running_o(running), .nrt_step_long_o(step_long), .nrt_compliance_o(cmpl)
    );
    always @(posedge clk) begin
        if (rf_off === 1'b1) fo_seen <= 1'b1;
        cyc <= cyc + 1;
        // Whole run needs about 3200 cycles
        if (cyc == 40000) begin
            bad_count++;
            results();
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        // Ends once pready is seen high; only the bench timeout ends a wait where it never rises
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
    endtask
    function automatic gptm_row_s mk(input logic [7:0] wa, input logic [7:0] wd,
                                     input int e, input logic [7:0] ra, input logic [7:0] ex);
        mk = '{wa, wd, e, ra, ex};
    endfunction
    task automatic run(input gptm_row_s r);
        logic st;
        apb(1'b1, r.wa, r.wd, rd, er);
        if (r.ev < NONE) pulse(r.ev);
        repeat (6) @(posedge clk);
        for (int k = 0; k < 400 && running === 1'b1; k++) @(posedge clk);
        repeat (4) @(posedge clk);
        st = (r.ra == MSTAT_ADDR || r.ra == TSTAT_ADDR);
        chk("irq", {31'h0, irq}, {31'h0, st && r.ex != 8'h00});
        apb(1'b0, r.ra, 8'h00, rd, er);
        chk("rdata", rd, {24'h000000, r.ex});
        repeat (2) @(posedge clk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rows = '{mk(TTC_ADDR, 8'hFF, NONE, TTC_ADDR, 8'hE3),
                 mk(GPT_HI_ADDR, 8'hA5, NONE, GPT_HI_ADDR, 8'hA5),
                 mk(GPT_LO_ADDR, 8'h5A, NONE, GPT_LO_ADDR, 8'h5A),
                 mk(MMASK_ADDR, 8'hFF, NONE, MMASK_ADDR, 8'hFC),
                 mk(TMASK_ADDR, 8'hFF, NONE, TMASK_ADDR, 8'hFF),
                 mk(GPT_HI_ADDR, 8'h00, NONE, GPT_HI_ADDR, 8'h00),
                 mk(GPT_LO_ADDR, 8'h01, NONE, GPT_LO_ADDR, 8'h01)};
        // Masked first, then clear, so each source leaves its mask at zero
        foreach (ma[i]) begin
            rows.push_back(mk(MMASK_ADDR, ma[i], me[i], MSTAT_ADDR, 8'h00));
            rows.push_back(mk(MMASK_ADDR, 8'h00, me[i], MSTAT_ADDR, ma[i]));
        end
        foreach (tm[i]) begin
            rows.push_back(mk(TMASK_ADDR, tm[i], i + 3, TSTAT_ADDR, 8'h00));
            rows.push_back(mk(TMASK_ADDR, 8'h00, i + 3, TSTAT_ADDR, tm[i]));
        end
        // Receive and transmit events masked so only the timer raises irq
        rows.push_back(mk(MMASK_ADDR, 8'hFC, NONE, MMASK_ADDR, 8'hFC));
        rows.push_back(mk(TTC_ADDR, 8'h20, RXE, TSTAT_ADDR, 8'h20));
        rows.push_back(mk(TTC_ADDR, 8'h20, RXS, TSTAT_ADDR, 8'h00));
        rows.push_back(mk(TTC_ADDR, 8'h20, TXE, TSTAT_ADDR, 8'h00));
        rows.push_back(mk(TTC_ADDR, 8'h40, RXE, TSTAT_ADDR, 8'h00));
        for (int c = 0; c < 8; c = c + (c == 0 ? 4 : 1)) begin
            rows.push_back(mk(TTC_ADDR, 8'(c << 5), RXE, TSTAT_ADDR, 8'h00));
            rows.push_back(mk(TTC_ADDR, 8'(c << 5), TXE, TSTAT_ADDR, 8'h00));
            rows.push_back(mk(TTC_ADDR, 8'(c << 5), CMD, TSTAT_ADDR, 8'h20));
        end
        rows.push_back(mk(TMASK_ADDR, 8'h20, CMD, TSTAT_ADDR, 8'h00));
        rows.push_back(mk(TMASK_ADDR, 8'h00, NONE, TMASK_ADDR, 8'h00));
        foreach (rows[i]) run(rows[i]);
        // Field switched off only after an end-of-transmit run
        fo_seen = 1'b0;
        run(mk(TTC_ADDR, 8'h40, RXS, TSTAT_ADDR, 8'h20));
        chk("field off", {31'h0, fo_seen}, 32'h0);
        run(mk(TTC_ADDR, 8'h60, TXE, TSTAT_ADDR, 8'h20));
        chk("field off", {31'h0, fo_seen}, 32'h1);
        // End of transmit outside NFC mode must not start the timer
        nfc <= 1'b0;
        run(mk(TTC_ADDR, 8'h60, TXE, TSTAT_ADDR, 8'h00));
        nfc <= 1'b1;
        // Stalled carrier holds the timer, resuming lets it expire
        fc_en = 1'b0;
        run(mk(TTC_ADDR, 8'h00, CMD, TSTAT_ADDR, 8'h00));
        chk("running", {31'h0, running}, 32'h1);
        fc_en = 1'b1;
        run(mk(GPT_LO_ADDR, 8'h01, NONE, TSTAT_ADDR, 8'h20));
        // Unmapped address refused
        apb(1'b0, 8'h00, 8'h00, rd, er);
        chk("slverr", {31'h0, er}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        // Step and mode bits, then set-default and a second reset
        apb(1'b1, TTC_ADDR, 8'h03, rd, er);
        repeat (2) @(posedge clk);
        chk("step", {31'h0, step_long}, 32'h1);
        chk("compliance", {31'h0, cmpl}, 32'h1);
        pulse(DEF);
        repeat (2) @(posedge clk);
        chk("step", {31'h0, step_long}, 32'h0);
        apb(1'b0, TTC_ADDR, 8'h00, rd, er);
        chk("ttc default", rd, 32'h0);
        // Status also clears by writing one to its bit
        pulse(0);
        apb(1'b1, MSTAT_ADDR, 8'h80, rd, er);
        apb(1'b0, MSTAT_ADDR, 8'h00, rd, er);
        chk("w1c", rd, 32'h0);
        apb(1'b1, TMASK_ADDR, 8'h5A, rd, er);
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 5; a++) begin
            apb(1'b0, 8'(TTC_ADDR + 4 * a), 8'h00, rd, er);
            chk("reset value", rd, 32'h0);
        end
        results();
    end
endmodule

/* verification/gptm_fc_src.sv */
// Carrier clock source standing in for the field oscillator beside the block
`timescale 1ns/1ps
module gptm_fc_src (
    // Control
    input  wire logic en_i,
    // Carrier
    output logic      fc_o
);
    // Free running about 13.5 MHz, unrelated in phase to the system clock
    // Stops low while disabled, so a stalled timer can be seen
    initial begin
        fc_o = 1'b0;
        forever begin
            #37;
            fc_o = en_i ? ~fc_o : 1'b0;
        end
    end
endmodule
